//--- capture_compare_pkg.sv
// Package: register map, field positions and types for the timer capture/compare block
`default_nettype none
package capture_compare_pkg;
  localparam int unsigned TIMER_WIDTH = 16;
  // Register byte addresses (word aligned)
  localparam logic [9:0] OFF_CONTROL    = 10'h000;
  localparam logic [9:0] OFF_COUNTER    = 10'h004;
  localparam logic [9:0] OFF_CAPTURE    = 10'h008;
  localparam logic [9:0] OFF_COMPARE    = 10'h00C;
  localparam logic [9:0] OFF_DMA_COUNT  = 10'h010;
  localparam logic [9:0] OFF_DMA_ADDR   = 10'h014;
  localparam logic [9:0] OFF_IRQ_STATUS = 10'h018;
  localparam logic [9:0] OFF_IRQ_MASK   = 10'h01C;
  // Mask register keeps its index; the bus sees it at four times the index
  localparam logic [7:0] OFF_MASK_REG   = 8'hFF;
  localparam logic [9:0] OFF_MASK_WORD  = {OFF_MASK_REG, 2'b00};
  // Mask register fields
  localparam int unsigned CAPTURE_DMA_BIT = 6;
  localparam int unsigned COMPARE_DMA_BIT = 3;
  // Control register fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_EDGE_BIT = 1;
  // Interrupt status fields
  localparam int unsigned IRQ_CAPTURE_BIT = 0;
  localparam int unsigned IRQ_COMPARE_BIT = 1;
  localparam int unsigned IRQ_BLOCK_BIT   = 2;
  // Reset values
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [1:0]  CONTROL_RESET = 2'h0;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    src_none,
    src_capture,
    src_compare
  } dma_source_e;

  typedef struct packed {
    logic        req;
    logic        write_to_timer;
    logic [15:0] addr;
    logic [15:0] data;
  } dma_request_s;

  typedef struct packed {
    logic        ack;
    logic        block_completion;
    logic        own;
    logic [15:0] data;
  } dma_answer_s;
endpackage
`default_nettype wire

//--- capture_compare.sv
// Capture/compare timer unit with DMA or interrupt servicing of its events
`default_nettype none
// Operation
// - Sixteen-bit counter with capture and compare
// - Trigger edge latches counter into capture register
// - Counter match toggles compare output pin
// - Each event raises interrupt if its enable is clear, else DMA request if none is pending, else nothing (capture wins a tie)
// - DMA moves capture/compare data without software
// - Mask bit 6 routes capture to DMA
// - Mask bit 3 routes compare to DMA
// - Counter and address registers define block
// - Own block completion clears matching enable bit
// - Ignore completions belonging to other requesters
// - Pending request survives foreign completion
// - Cleared enable stops further DMA requests
// - Cleared enable sends events to interrupt
module capture_compare
  import capture_compare_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [9:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         capture_pin,
  output logic              compare_pin,
  output logic              irq,
  output dma_request_s      dma_req,
  input  wire dma_answer_s  dma_ans,
  output logic [15:0]       dma_count,
  output logic [15:0]       dma_addr
);
  logic [WIDTH-1:0] counter;
  logic [WIDTH-1:0] capture_value_reg;
  logic [WIDTH-1:0] compare_value_reg;
  logic [7:0]       interrupt_dma_mask;
  logic [1:0]       control;
  logic [2:0]       irq_status;
  logic [2:0]       irq_mask;
  logic [1:0]       cap_sync;
  logic             cap_prev;
  dma_source_e      pending;
  logic             access_done;

  // Pin crossing: first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync <= 2'h0;
      cap_prev <= 1'b0;
    end else if (clk_en) begin
      cap_sync <= {cap_sync[0], capture_pin};
      cap_prev <= cap_sync[1];
    end
  end

  // Decode
  wire       bus_write     = psel && penable && pwrite && !access_done;
  wire       bus_read      = psel && penable && !pwrite && !access_done;
  wire       hit_control   = paddr == OFF_CONTROL;
  wire       hit_counter   = paddr == OFF_COUNTER;
  wire       hit_capture   = paddr == OFF_CAPTURE;
  wire       hit_compare   = paddr == OFF_COMPARE;
  wire       hit_count     = paddr == OFF_DMA_COUNT;
  wire       hit_addr      = paddr == OFF_DMA_ADDR;
  wire       hit_status    = paddr == OFF_IRQ_STATUS;
  wire       hit_imask     = paddr == OFF_IRQ_MASK;
  // Only the aligned word address of the mask index is decoded
  wire       hit_mask      = paddr == OFF_MASK_WORD;
  wire       hit_any       = hit_control || hit_counter || hit_capture || hit_compare ||
                             hit_count || hit_addr || hit_status || hit_imask || hit_mask;
  wire       running       = control[CTRL_RUN_BIT];
  wire       cap_level     = control[CTRL_EDGE_BIT] ? !cap_sync[1] : cap_sync[1];
  wire       cap_prev_lvl  = control[CTRL_EDGE_BIT] ? !cap_prev : cap_prev;
  wire       capture_event = running && cap_level && !cap_prev_lvl;
  wire       compare_event = running && (counter == compare_value_reg);
  wire       cap_dma_en    = interrupt_dma_mask[CAPTURE_DMA_BIT];
  wire       cmp_dma_en    = interrupt_dma_mask[COMPARE_DMA_BIT];
  // Each event picks exactly one path from its enable bit
  wire       cap_to_dma    = capture_event && cap_dma_en;
  wire       cmp_to_dma    = compare_event && cmp_dma_en;
  wire       cap_to_irq    = capture_event && !cap_dma_en;
  wire       cmp_to_irq    = compare_event && !cmp_dma_en;
  // Only a completion tagged as ours may clear an enable; others pass by
  wire       own_done      = dma_ans.ack && dma_ans.own && dma_ans.block_completion;
  wire       own_ack       = dma_ans.ack && dma_ans.own;
  wire       clr_cap_en    = own_done && (pending == src_capture);
  wire       clr_cmp_en    = own_done && (pending == src_compare);
  wire       mask_wr       = bus_write && hit_mask;
  wire [2:0] irq_events    = {own_done, cmp_to_irq, cap_to_irq};
  wire [2:0] status_clr    = (bus_write && hit_status) ? pwdata[2:0] : 3'h0;
  wire [2:0] next_status   = (irq_status & ~status_clr) | irq_events;
  wire [WIDTH-1:0] next_counter = counter + WIDTH'(1);

  // Zero-extend a timer-width value onto the 32-bit read bus
  function automatic logic [31:0] word_of(input logic [WIDTH-1:0] value);
    word_of = {{(32-WIDTH){1'b0}}, value};
  endfunction

  // Read mux
  wire [31:0] read_word =
    hit_control ? {30'h0, control} :
    hit_counter ? word_of(counter) :
    hit_capture ? word_of(capture_value_reg) :
    hit_compare ? word_of(compare_value_reg) :
    hit_count   ? {16'h0, dma_count} :
    hit_addr    ? {16'h0, dma_addr} :
    hit_status  ? {29'h0, irq_status} :
    hit_imask   ? {29'h0, irq_mask} :
    hit_mask    ? {24'h0, interrupt_dma_mask} : 32'h0;

  // APB slave: one wait state in each access phase, ready pulses on the following edge
  // Writes land on the same edge that raises ready, so the master must hold the request until then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0;
      access_done <= 1'b0;
    end else if (clk_en) begin
      pready      <= psel && penable && !access_done;
      pslverr     <= psel && penable && !access_done && !hit_any;
      access_done <= psel && penable && !access_done;
      if (bus_read) begin
        prdata <= read_word;
      end
    end
  end

  // Counter; a software write takes precedence over the count step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= COUNT_RESET;
    end else if (clk_en) begin
      if (bus_write && hit_counter) begin
        counter <= pwdata[WIDTH-1:0];
      end else if (running) begin
        counter <= next_counter;
      end
    end
  end

  // Capture register; a trigger wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_reg <= COUNT_RESET;
    end else if (clk_en) begin
      if (capture_event) begin
        capture_value_reg <= counter;
      end else if (bus_write && hit_capture) begin
        capture_value_reg <= pwdata[WIDTH-1:0];
      end
    end
  end

  // DMA write-back into the compare register happens without software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_reg <= COUNT_RESET;
    end else if (clk_en) begin
      if (own_ack && pending == src_compare) begin
        compare_value_reg <= dma_ans.data[WIDTH-1:0];
      end else if (bus_write && hit_compare) begin
        compare_value_reg <= pwdata[WIDTH-1:0];
      end
    end
  end

  // Compare pin toggles on every cycle of a match while the counter runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin <= 1'b0;
    end else if (clk_en) begin
      if (compare_event) begin
        compare_pin <= !compare_pin;
      end
    end
  end

  // Control and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control  <= CONTROL_RESET;
      irq_mask <= IRQ_RESET;
    end else if (clk_en) begin
      if (bus_write && hit_control) begin
        control <= pwdata[1:0];
      end
      if (bus_write && hit_imask) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end

  // Enable bits: hardware clear on own completion; a software write of one re-arms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_dma_mask <= MASK_RESET;
    end else if (clk_en) begin
      if (mask_wr) begin
        interrupt_dma_mask <= pwdata[7:0];
      end else begin
        if (clr_cap_en) begin
          interrupt_dma_mask[CAPTURE_DMA_BIT] <= 1'b0;
        end
        if (clr_cmp_en) begin
          interrupt_dma_mask[COMPARE_DMA_BIT] <= 1'b0;
        end
      end
    end
  end

  // DMA block descriptor; software owns it, our acks advance it
  // Count holds at zero rather than wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_count <= 16'h0;
    end else if (clk_en) begin
      if (bus_write && hit_count) begin
        dma_count <= pwdata[15:0];
      end else if (own_ack && dma_count != 16'h0) begin
        dma_count <= dma_count - 16'h1;
      end
    end
  end

  // Address steps by one word per served transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_addr <= 16'h0;
    end else if (clk_en) begin
      if (bus_write && hit_addr) begin
        dma_addr <= pwdata[15:0];
      end else if (own_ack) begin
        dma_addr <= dma_addr + 16'h1;
      end
    end
  end

  // Request stays raised until our own ack; foreign completions cannot drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= src_none;
      dma_req <= '0;
    end else if (clk_en) begin
      case (pending)
        src_none: begin
          if (cap_to_dma) begin
            pending <= src_capture;
            // Counter itself: the capture register only takes it at this same edge
            dma_req <= '{req: 1'b1, write_to_timer: 1'b0, addr: dma_addr,
                         data: 16'(counter)};
          end else if (cmp_to_dma) begin
            pending <= src_compare;
            dma_req <= '{req: 1'b1, write_to_timer: 1'b1, addr: dma_addr, data: 16'h0};
          end
        end
        src_capture, src_compare: begin
          if (own_ack) begin
            pending <= src_none;
            dma_req <= '0;
          end
        end
        default: begin
          pending <= src_none;
          dma_req <= '0;
        end
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= IRQ_RESET;
    end else if (clk_en) begin
      irq_status <= next_status;
    end
  end

  // Level follows the next status, so it rises in step with the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

//--- capture_compare_monitor.sv
// Concurrent checks on the timer block's bus answer and DMA request ports
`default_nettype none
module capture_compare_monitor
  import capture_compare_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire dma_request_s dma_req,
  input wire dma_answer_s  dma_ans,
  input wire logic [15:0]  dma_count,
  input wire logic [15:0]  dma_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence own_ack;
    clk_en && dma_req.req && dma_ans.ack && dma_ans.own;
  endsequence
  sequence foreign_ack;
    clk_en && dma_req.req && dma_ans.ack && !dma_ans.own;
  endsequence
  a_ready_pulse: assert property (clk_en && pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_next: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_req_held: assert property (dma_req.req && !dma_ans.ack |=> dma_req.req)
    else $error("request dropped before answer");
  a_req_drop: assert property (own_ack |=> !dma_req.req)
    else $error("request kept after own answer");
  a_count_step: assert property (own_ack |=> dma_count == $past(dma_count) - 16'h0001)
    else $error("count not stepped down");
  a_addr_step: assert property (own_ack |=> dma_addr == $past(dma_addr) + 16'h0001)
    else $error("address not stepped up");
  // A completion meant for another requester must leave this one untouched
  a_foreign_kept: assert property (foreign_ack |=> dma_req.req && $stable(dma_count))
    else $error("foreign answer disturbed request");
endmodule
bind capture_compare capture_compare_monitor mon (.pclk, .presetn, .clk_en, .psel, .penable,
  .pready, .pslverr, .dma_req, .dma_ans, .dma_count, .dma_addr);
`default_nettype wire

//--- dma_partner.sv
// Behavioural DMA controller and arbiter facing the timer's request port
`default_nettype none
module dma_partner
  import capture_compare_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire dma_request_s dma_req,
  input  wire logic [15:0]  dma_count,
  input  wire logic [3:0]   dly,
  input  wire logic         foreign,
  output var dma_answer_s   dma_ans
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // A long dly stands in for arbitration lost to higher-priority requesters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      dma_ans  <= '0;
    end else begin
      // Idle data toggles so a stale word is never taken for a load
      dma_ans <= {3'b000, ~dma_ans.data};
      if (foreign) begin
        dma_ans <= {3'b110, 16'h0000};
      end else if (dma_req.req && !dma_ans.ack) begin
        wait_cnt <= (wait_cnt == dly) ? 4'h0 : wait_cnt + 4'h1;
        if (wait_cnt == dly)
          dma_ans <= {1'b1, dma_count == 16'h0001, 1'b1, 16'h1234};
      end
    end
  end
endmodule
`default_nettype wire

//--- timer_capture_compare_dma_request_test.sv
// Testbench: register access, DMA routing and interrupt fallback of the timer
`default_nettype none
module timer_capture_compare_dma_request_test
  import capture_compare_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [9:0] a; logic [31:0] d, q; logic e;} row_s;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic         capture_pin = 0, foreign = 0, pready, pslverr, compare_pin, irq, er, pin0;
  logic [9:0]   paddr = 10'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [3:0]   dly = 4'h0;
  logic [15:0]  dma_count, dma_addr, cap_word;
  dma_request_s dma_req;
  dma_answer_s  dma_ans;
  int           fail_count = 0, n_tests = 0;
  row_s rows [7] = '{'{OFF_MASK_WORD, 32'h48, 32'h48, 1'b0}, '{OFF_DMA_COUNT, 32'h2, 32'h2, 1'b0},
    '{OFF_DMA_ADDR, 32'h100, 32'h100, 1'b0}, '{OFF_IRQ_MASK, 32'h7, 32'h7, 1'b0},
    '{OFF_COMPARE, 32'hFFFF, 32'hFFFF, 1'b0}, '{OFF_CONTROL, 32'h1, 32'h1, 1'b0},
    '{10'h020, 32'h1, 32'h0, 1'b1}};
  always #5 pclk = ~pclk;
  capture_compare dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .capture_pin, .compare_pin, .irq, .dma_req,
    .dma_ans, .dma_count, .dma_addr);
  dma_partner far (.pclk, .presetn, .dma_req, .dma_count, .dly, .foreign, .dma_ans);
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic close_fail();
    fail_count++;
    close_out();
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic [9:0] a, input logic [31:0] d, input logic w);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 50) close_fail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(a, d, 1'b1);
  endtask
  task automatic rc(input string n, input logic [9:0] a, input logic [31:0] e);
    apb(a, 32'h0, 1'b0);
    chk(n, e, rd);
  endtask
  task automatic till_req(input logic v);
    int k;
    for (k = 0; k < 80 && dma_req.req !== v; k++) @(posedge pclk);
    if (k == 80) close_fail();
  endtask
  task automatic pulse();
    @(posedge pclk);
    capture_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    capture_pin <= 1'b0;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc("mask_reset", OFF_MASK_WORD, {24'h0, MASK_RESET});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
      if (!rows[i].e) rc("readback", rows[i].a, rows[i].q);
    end
    $display("test registers finished");
    pulse();
    till_req(1'b1);
    cap_word = dma_req.data;
    chk("to_memory", 32'h0, {31'h0, dma_req.write_to_timer});
    chk("req_addr", 32'h100, {16'h0, dma_req.addr});
    till_req(1'b0);
    chk("count", 32'h1, {16'h0, dma_count});
    chk("addr", 32'h101, {16'h0, dma_addr});
    rc("cap_data", OFF_CAPTURE, {16'h0, cap_word});
    $display("test capture_dma finished");
    dly <= 4'hA;
    pulse();
    till_req(1'b1);
    @(posedge pclk) foreign <= 1'b1;
    @(posedge pclk) foreign <= 1'b0;
    rc("mask_kept", OFF_MASK_WORD, 32'h48);
    chk("req_kept", 32'h1, {31'h0, dma_req.req});
    till_req(1'b0);
    rc("mask_capture_off", OFF_MASK_WORD, 32'h08);
    $display("test foreign_completion finished");
    pulse();
    repeat (6) @(posedge pclk);
    chk("no_req", 32'h0, {31'h0, dma_req.req});
    rc("status", OFF_IRQ_STATUS, 32'h5);
    rc("count_zero", OFF_DMA_COUNT, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(OFF_IRQ_MASK, 32'h7);
    irq_is(1'b1);
    wr(OFF_IRQ_STATUS, 32'h7);
    irq_is(1'b0);
    $display("test interrupt_path finished");
    wr(OFF_DMA_COUNT, 32'h1);
    wr(OFF_COMPARE, 32'h5);
    pin0 = compare_pin;
    wr(OFF_COUNTER, 32'h3);
    till_req(1'b1);
    chk("to_timer", 32'h1, {31'h0, dma_req.write_to_timer});
    till_req(1'b0);
    chk("pin", {31'h0, ~pin0}, {31'h0, compare_pin});
    rc("cmp_load", OFF_COMPARE, 32'h1234);
    rc("mask_compare_off", OFF_MASK_WORD, 32'h00);
    $display("test compare_dma finished");
    wr(OFF_MASK_WORD, 32'h48);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset_req", 32'h0, {31'h0, dma_req.req});
    chk("reset_pin", 32'h0, {31'h0, compare_pin});
    presetn <= 1'b1;
    rc("mask_after_reset", OFF_MASK_WORD, {24'h0, MASK_RESET});
    $display("test reset finished");
    close_out();
  end
endmodule
`default_nettype wire
